// file: logic/bit_reversed_modulo_agu.sv
// Data address generators: modulo wrap, bit-reversed writes, APB register file
module bit_reversed_modulo_agu
    import agu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic xw_valid,
    input wire logic [SEL_W-1:0] xw_ptr_sel,
    input wire logic [ADDR_W-1:0] xw_ptr,
    input wire addr_mode_e xw_mode,
    input wire logic [ADDR_W-1:0] xw_offset,
    input wire logic xw_byte,
    output logic xw_addr_valid,
    output logic [ADDR_W-1:0] xw_addr,
    output logic xw_wb_en,
    output logic [SEL_W-1:0] xw_wb_sel,
    output logic [ADDR_W-1:0] xw_wb_data,
    input wire logic xr_valid,
    input wire logic [SEL_W-1:0] xr_ptr_sel,
    input wire logic [ADDR_W-1:0] xr_ptr,
    input wire addr_mode_e xr_mode,
    input wire logic [ADDR_W-1:0] xr_offset,
    input wire logic xr_byte,
    output logic xr_addr_valid,
    output logic [ADDR_W-1:0] xr_addr,
    output logic xr_wb_en,
    output logic [SEL_W-1:0] xr_wb_sel,
    output logic [ADDR_W-1:0] xr_wb_data,
    input wire logic y_valid,
    input wire logic [SEL_W-1:0] y_ptr_sel,
    input wire logic [ADDR_W-1:0] y_ptr,
    input wire addr_mode_e y_mode,
    input wire logic [ADDR_W-1:0] y_offset,
    input wire logic y_byte,
    output logic y_addr_valid,
    output logic [ADDR_W-1:0] y_addr,
    output logic y_wb_en,
    output logic [SEL_W-1:0] y_wb_sel,
    output logic [ADDR_W-1:0] y_wb_data
);
    logic [15:0] modulo_control_reg_r;
    logic [15:0] bit_reverse_control_reg_r;
    logic [ADDR_W-1:0] x_start_r, x_end_r, y_start_r, y_end_r;
    logic brev_last_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic xw_addr_valid_r, xw_wb_en_r, xr_addr_valid_r, xr_wb_en_r, y_addr_valid_r, y_wb_en_r;
    logic [ADDR_W-1:0] xw_addr_r, xw_wb_data_r, xr_addr_r, xr_wb_data_r, y_addr_r, y_wb_data_r;
    logic [SEL_W-1:0] xw_wb_sel_r, xr_wb_sel_r, y_wb_sel_r;

    // Register fields
    wire logic x_mod_en = modulo_control_reg_r[MC_XMOD_EN_BIT];
    wire logic y_mod_en = modulo_control_reg_r[MC_YMOD_EN_BIT];
    wire logic [SEL_W-1:0] bit_reverse_pointer_select =
        modulo_control_reg_r[MC_BRSEL_LSB +: SEL_W];
    wire logic [SEL_W-1:0] x_mod_sel = modulo_control_reg_r[MC_XSEL_LSB +: SEL_W];
    wire logic [SEL_W-1:0] y_mod_sel = modulo_control_reg_r[MC_YSEL_LSB +: SEL_W];
    wire logic bit_reverse_enable = bit_reverse_control_reg_r[BR_EN_BIT];
    wire logic [PIVOT_W-1:0] reverse_pivot_modifier = bit_reverse_control_reg_r[PIVOT_W-1:0];

    // New settings apply from the edge after the write is taken
    wire logic brev_cfg_on = bit_reverse_enable && (bit_reverse_pointer_select != STACK_SEL);

    // APB decode
    wire logic apb_access = psel && penable;
    wire logic apb_done = apb_access && pready_r;
    wire logic apb_wr = apb_done && pwrite;
    wire logic hit_mc = (paddr == OFS_MODULO_CTRL);
    wire logic hit_br = (paddr == OFS_BREV_CTRL);
    wire logic hit_xs = (paddr == OFS_X_START);
    wire logic hit_xe = (paddr == OFS_X_END);
    wire logic hit_ys = (paddr == OFS_Y_START);
    wire logic hit_ye = (paddr == OFS_Y_END);
    wire logic hit_st = (paddr == OFS_STATUS);
    wire logic hit_any = hit_mc || hit_br || hit_xs || hit_xe || hit_ys || hit_ye || hit_st;
    wire logic [31:0] status_word = {15'h0000, brev_last_r, xw_addr_r};
    wire logic [31:0] rd_mux = hit_mc ? {16'h0000, modulo_control_reg_r} :
                               hit_br ? {16'h0000, bit_reverse_control_reg_r} :
                               hit_xs ? {16'h0000, x_start_r} :
                               hit_xe ? {16'h0000, x_end_r} :
                               hit_ys ? {16'h0000, y_start_r} :
                               hit_ye ? {16'h0000, y_end_r} :
                               hit_st ? status_word : RST_PRDATA;

    // Modulo settings per unit; reversal switches modulo off in X write and Y
    modulo_cfg_if xr_cfg ();
    modulo_cfg_if xw_cfg ();
    modulo_cfg_if y_cfg ();
    assign xr_cfg.en = x_mod_en;
    assign xr_cfg.sel = x_mod_sel;
    assign xr_cfg.start_addr = x_start_r;
    assign xr_cfg.end_addr = x_end_r;
    assign xw_cfg.en = x_mod_en && !brev_cfg_on;
    assign xw_cfg.sel = x_mod_sel;
    assign xw_cfg.start_addr = x_start_r;
    assign xw_cfg.end_addr = x_end_r;
    assign y_cfg.en = y_mod_en && !brev_cfg_on;
    assign y_cfg.sel = y_mod_sel;
    assign y_cfg.start_addr = y_start_r;
    assign y_cfg.end_addr = y_end_r;

    logic [ADDR_W-1:0] xr_ea, xr_wbd, xw_ea_n, xw_wbd_n, y_ea, y_wbd;
    logic xr_wbe, xw_wbe_n, y_wbe;

    modulo_ea_calc u_x_read (
        .cfg(xr_cfg.sink), .ptr_sel(xr_ptr_sel), .ptr(xr_ptr), .mode(xr_mode),
        .offset(xr_offset), .byte_sz(xr_byte), .ea(xr_ea), .wb_en(xr_wbe), .wb_data(xr_wbd)
    );
    modulo_ea_calc u_x_write (
        .cfg(xw_cfg.sink), .ptr_sel(xw_ptr_sel), .ptr(xw_ptr), .mode(xw_mode),
        .offset(xw_offset), .byte_sz(xw_byte), .ea(xw_ea_n), .wb_en(xw_wbe_n),
        .wb_data(xw_wbd_n)
    );
    modulo_ea_calc u_y (
        .cfg(y_cfg.sink), .ptr_sel(y_ptr_sel), .ptr(y_ptr), .mode(y_mode),
        .offset(y_offset), .byte_sz(y_byte), .ea(y_ea), .wb_en(y_wbe), .wb_data(y_wbd)
    );

    // Bit-reversed path, X write unit only
    wire logic xw_inc_mode = (xw_mode == AM_PRE_INC) || (xw_mode == AM_POST_INC);
    wire logic brev_act = brev_cfg_on && (xw_ptr_sel == bit_reverse_pointer_select) &&
                          xw_inc_mode && !xw_byte;
    logic [PIVOT_W-1:0] rev_sum;
    // Word address in bits 15:1 so the pivot counts words
    rev_carry_adder #(.W(PIVOT_W)) u_rev_add (
        .a(xw_ptr[ADDR_W-1:1]), .b(reverse_pivot_modifier), .sum(rev_sum)
    );
    wire logic [ADDR_W-1:0] rev_next = {rev_sum, 1'b0};
    wire logic [ADDR_W-1:0] rev_ea = (xw_mode == AM_PRE_INC) ? rev_next :
                                     {xw_ptr[ADDR_W-1:1], 1'b0};
    wire logic [ADDR_W-1:0] xw_ea = brev_act ? rev_ea : xw_ea_n;
    wire logic [ADDR_W-1:0] xw_wbd = brev_act ? rev_next : xw_wbd_n;
    wire logic xw_wbe = brev_act || xw_wbe_n;

    // APB slave: one wait state, write lands on the completing edge
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= RST_PRDATA;
        end else if (ce) begin
            pready_r <= apb_access && !pready_r;
            pslverr_r <= apb_access && !pready_r && !hit_any;
            prdata_r <= (apb_access && !pready_r && !pwrite) ? rd_mux : RST_PRDATA;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            modulo_control_reg_r <= RST_MODULO_CTRL;
            bit_reverse_control_reg_r <= RST_BREV_CTRL;
            x_start_r <= RST_ADDR;
            x_end_r <= RST_ADDR;
            y_start_r <= RST_ADDR;
            y_end_r <= RST_ADDR;
        end else if (ce && apb_wr) begin
            if (hit_mc) modulo_control_reg_r <= pwdata[15:0];
            if (hit_br) bit_reverse_control_reg_r <= pwdata[15:0];
            if (hit_xs) x_start_r <= pwdata[ADDR_W-1:0];
            if (hit_xe) x_end_r <= pwdata[ADDR_W-1:0];
            if (hit_ys) y_start_r <= pwdata[ADDR_W-1:0];
            if (hit_ye) y_end_r <= pwdata[ADDR_W-1:0];
        end
    end

    // Registered outputs of the three units
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            xw_addr_valid_r <= 1'b0;
            xw_addr_r <= RST_ADDR;
            xw_wb_en_r <= 1'b0;
            xw_wb_sel_r <= '0;
            xw_wb_data_r <= RST_ADDR;
            brev_last_r <= 1'b0;
        end else if (ce) begin
            xw_addr_valid_r <= xw_valid;
            xw_wb_en_r <= xw_valid && xw_wbe;
            if (xw_valid) begin
                xw_addr_r <= xw_ea;
                xw_wb_sel_r <= xw_ptr_sel;
                xw_wb_data_r <= xw_wbd;
                brev_last_r <= brev_act;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            xr_addr_valid_r <= 1'b0;
            xr_addr_r <= RST_ADDR;
            xr_wb_en_r <= 1'b0;
            xr_wb_sel_r <= '0;
            xr_wb_data_r <= RST_ADDR;
        end else if (ce) begin
            xr_addr_valid_r <= xr_valid;
            xr_wb_en_r <= xr_valid && xr_wbe;
            if (xr_valid) begin
                xr_addr_r <= xr_ea;
                xr_wb_sel_r <= xr_ptr_sel;
                xr_wb_data_r <= xr_wbd;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            y_addr_valid_r <= 1'b0;
            y_addr_r <= RST_ADDR;
            y_wb_en_r <= 1'b0;
            y_wb_sel_r <= '0;
            y_wb_data_r <= RST_ADDR;
        end else if (ce) begin
            y_addr_valid_r <= y_valid;
            y_wb_en_r <= y_valid && y_wbe;
            if (y_valid) begin
                y_addr_r <= y_ea;
                y_wb_sel_r <= y_ptr_sel;
                y_wb_data_r <= y_wbd;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign xw_addr_valid = xw_addr_valid_r;
    assign xw_addr = xw_addr_r;
    assign xw_wb_en = xw_wb_en_r;
    assign xw_wb_sel = xw_wb_sel_r;
    assign xw_wb_data = xw_wb_data_r;
    assign xr_addr_valid = xr_addr_valid_r;
    assign xr_addr = xr_addr_r;
    assign xr_wb_en = xr_wb_en_r;
    assign xr_wb_sel = xr_wb_sel_r;
    assign xr_wb_data = xr_wb_data_r;
    assign y_addr_valid = y_addr_valid_r;
    assign y_addr = y_addr_r;
    assign y_wb_en = y_wb_en_r;
    assign y_wb_sel = y_wb_sel_r;
    assign y_wb_data = y_wb_data_r;

    // Reference reversed sum for checking
    function automatic logic [PIVOT_W-1:0] flip15(input logic [PIVOT_W-1:0] v);
        logic [PIVOT_W-1:0] r;
        for (int i = 0; i < PIVOT_W; i++) r[i] = v[PIVOT_W-1-i];
        return r;
    endfunction
    wire logic [PIVOT_W-1:0] ref_rev =
        flip15(PIVOT_W'(flip15(xw_ptr[ADDR_W-1:1]) + flip15(reverse_pivot_modifier)));
    wire logic xr_mod_hit = x_mod_en && (xr_ptr_sel == x_mod_sel) && !xr_byte;
    wire logic [ADDR_W-1:0] xr_step_sum = ADDR_W'(xr_ptr + WORD_STEP);
    wire logic [ADDR_W-1:0] x_len = ADDR_W'(x_end_r - x_start_r + LEN_ADJ);
    wire logic y_mod_hit = y_mod_en && !brev_cfg_on &&
        (y_ptr_sel == y_mod_sel) && !y_byte;
    wire logic [ADDR_W-1:0] y_step_dif = ADDR_W'(y_ptr - WORD_STEP);
    wire logic [ADDR_W-1:0] y_len = ADDR_W'(y_end_r - y_start_r + LEN_ADJ);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_apb_wait;
        psel && penable && !pready_r && ce;
    endsequence
    sequence s_apb_finish;
        pready_r ##1 !pready_r;
    endsequence

    chk_brev_lsb_clear: assert property (ce && xw_valid && brev_act |=> !xw_addr_r[0])
        else $error("reversed write address has bit zero set");
    chk_brev_sum_ok: assert property (ce && xw_valid && brev_act
        |=> xw_wb_data_r == {$past(ref_rev), 1'b0} && xw_wb_en_r)
        else $error("reversed write-back differs from reference sum");
    chk_read_post_plain: assert property (ce && xr_valid && xr_mode == AM_POST_INC
        |=> xr_addr_r == $past(xr_ptr))
        else $error("post-increment read address not the pointer");
    chk_offset_no_wb: assert property (ce && xr_valid && xr_mode == AM_OFFSET
        |=> !xr_wb_en_r && xr_addr_valid_r)
        else $error("offset mode asked for pointer write-back");
    chk_modify_wb: assert property (ce && y_valid && (y_mode == AM_PRE_DEC ||
        y_mode == AM_POST_DEC) |=> y_wb_en_r)
        else $error("modify mode lost its write-back");
    chk_stack_excluded: assert property (xw_ptr_sel == STACK_SEL |-> !brev_act)
        else $error("stack pointer took reversed addressing");
    chk_byte_normal: assert property (ce && xw_valid && xw_byte
        && xw_mode == AM_PRE_INC && brev_cfg_on
        |=> xw_addr_r == $past(xw_ptr) + BYTE_STEP)
        else $error("byte write did not get a normal address");
    chk_modulo_wrap: assert property (ce && xr_valid && xr_mode == AM_PRE_INC
        && xr_mod_hit && xr_step_sum > x_end_r
        |=> xr_addr_r == $past(ADDR_W'(xr_step_sum - x_len)))
        else $error("read address past upper limit not wrapped");
    chk_apb_onewait: assert property (s_apb_wait |=> s_apb_finish)
        else $error("register access did not finish after one wait");
    chk_lower_wrap: assert property (ce && y_valid && y_mode == AM_PRE_DEC
        && y_mod_hit && y_step_dif < y_start_r
        |=> y_addr_r == $past(ADDR_W'(y_step_dif + y_len)))
        else $error("no wrap below start");
    chk_y_mod_off: assert property (ce && y_valid && y_mode == AM_PRE_INC
        && brev_cfg_on && !y_byte
        |=> y_addr_r == $past(ADDR_W'(y_ptr + WORD_STEP)))
        else $error("Y unit wrapped");
    chk_brev_post_ea: assert property (ce && xw_valid && brev_act
        && xw_mode == AM_POST_INC
        |=> xw_addr_r == {$past(xw_ptr[ADDR_W-1:1]), 1'b0})
        else $error("reversed post address");
    chk_brev_pre_ea: assert property (ce && xw_valid && brev_act
        && xw_mode == AM_PRE_INC
        |=> xw_addr_r == xw_wb_data_r)
        else $error("reversed pre address");
    chk_wb_pulse: assert property (ce && !xw_valid
        |=> !xw_wb_en_r
        && !xw_addr_valid_r)
        else $error("write-back without request");
    chk_err_ready: assert property (pslverr_r
        |-> pready_r)
        else $error("error without ready");
endmodule

// file: logic/agu_pkg.sv
// Constants, offsets and types shared by the address generation logic
package agu_pkg;
    localparam int ADDR_W = 16;
    localparam int PIVOT_W = 15;
    localparam int SEL_W = 4;
    localparam int PADDR_W = 12;
    localparam logic [SEL_W-1:0] STACK_SEL = 4'hF;
    localparam logic [ADDR_W-1:0] WORD_STEP = 16'h0002;
    localparam logic [ADDR_W-1:0] BYTE_STEP = 16'h0001;
    localparam logic [ADDR_W-1:0] LEN_ADJ = 16'h0001;
    // Register byte offsets
    localparam logic [PADDR_W-1:0] OFS_MODULO_CTRL = 12'h000;
    localparam logic [PADDR_W-1:0] OFS_BREV_CTRL = 12'h004;
    localparam logic [PADDR_W-1:0] OFS_X_START = 12'h008;
    localparam logic [PADDR_W-1:0] OFS_X_END = 12'h00C;
    localparam logic [PADDR_W-1:0] OFS_Y_START = 12'h010;
    localparam logic [PADDR_W-1:0] OFS_Y_END = 12'h014;
    localparam logic [PADDR_W-1:0] OFS_STATUS = 12'h018;
    // Field positions
    localparam int MC_XMOD_EN_BIT = 15;
    localparam int MC_YMOD_EN_BIT = 14;
    localparam int MC_BRSEL_LSB = 8;
    localparam int MC_YSEL_LSB = 4;
    localparam int MC_XSEL_LSB = 0;
    localparam int BR_EN_BIT = 15;
    localparam int ST_BREV_BIT = 16;
    // Values after reset
    localparam logic [15:0] RST_MODULO_CTRL = 16'h0FFF;
    localparam logic [15:0] RST_BREV_CTRL = 16'h0000;
    localparam logic [ADDR_W-1:0] RST_ADDR = 16'h0000;
    localparam logic [31:0] RST_PRDATA = 32'h0000_0000;

    typedef enum logic [2:0] {
        AM_DIRECT,
        AM_POST_INC,
        AM_POST_DEC,
        AM_PRE_INC,
        AM_PRE_DEC,
        AM_OFFSET
    } addr_mode_e;
endpackage

// file: logic/modulo_cfg_if.sv
// Modulo buffer settings handed from the register file to one address unit
interface modulo_cfg_if;
    logic en;
    logic [3:0] sel;
    logic [15:0] start_addr;
    logic [15:0] end_addr;
    modport src (output en, sel, start_addr, end_addr);
    modport sink (input en, sel, start_addr, end_addr);
endinterface

// file: logic/modulo_ea_calc.sv
// Effective address and write-back value of one address unit, with modulo wrap
module modulo_ea_calc
    import agu_pkg::*;
(
    modulo_cfg_if.sink cfg,
    input wire logic [SEL_W-1:0] ptr_sel,
    input wire logic [ADDR_W-1:0] ptr,
    input wire addr_mode_e mode,
    input wire logic [ADDR_W-1:0] offset,
    input wire logic byte_sz,
    output logic [ADDR_W-1:0] ea,
    output logic wb_en,
    output logic [ADDR_W-1:0] wb_data
);
    wire logic is_inc = (mode == AM_POST_INC) || (mode == AM_PRE_INC);
    wire logic is_dec = (mode == AM_POST_DEC) || (mode == AM_PRE_DEC);
    wire logic is_pre = (mode == AM_PRE_INC) || (mode == AM_PRE_DEC);
    wire logic is_off = (mode == AM_OFFSET);
    wire logic [ADDR_W-1:0] step = byte_sz ? BYTE_STEP : WORD_STEP;
    wire logic [ADDR_W-1:0] modified = is_inc ? ADDR_W'(ptr + step) :
                                       is_dec ? ADDR_W'(ptr - step) :
                                       is_off ? ADDR_W'(ptr + offset) : ptr;
    wire logic use_mod = cfg.en && (ptr_sel == cfg.sel);
    wire logic [ADDR_W-1:0] buf_len = ADDR_W'(cfg.end_addr - cfg.start_addr + LEN_ADJ);
    wire logic going_up = is_inc || (is_off && !offset[ADDR_W-1]);
    wire logic going_down = is_dec || (is_off && offset[ADDR_W-1]);
    // Beyond the limit, not only equal to it
    wire logic past_hi = going_up && (modified > cfg.end_addr);
    wire logic past_lo = going_down && (modified < cfg.start_addr);
    wire logic [ADDR_W-1:0] corrected = !use_mod ? modified :
                                        past_hi ? ADDR_W'(modified - buf_len) :
                                        past_lo ? ADDR_W'(modified + buf_len) : modified;

    assign ea = (is_pre || is_off) ? corrected : ptr;
    assign wb_en = is_inc || is_dec;
    assign wb_data = corrected;
endmodule

// file: logic/rev_carry_adder.sv
// Adder whose carries run from the top bit down toward bit zero
module rev_carry_adder #(
    parameter int W = 15
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    output logic [W-1:0] sum
);
    logic [W:0] carry;
    assign carry[W] = 1'b0;
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign sum[i] = a[i] ^ b[i] ^ carry[i+1];
        assign carry[i] = (a[i] & b[i]) | (carry[i+1] & (a[i] ^ b[i]));
    end
endmodule

// file: test/pointer_file_model.sv
// Pipeline-side pointer register file feeding and absorbing the address units
module pointer_file_model
    import agu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic load_en,
    input wire logic [SEL_W-1:0] load_sel,
    input wire logic [ADDR_W-1:0] load_val,
    input wire logic wb_en [3],
    input wire logic [SEL_W-1:0] wb_sel [3],
    input wire logic [ADDR_W-1:0] wb_data [3],
    input wire logic [SEL_W-1:0] rd_sel [3],
    output logic [ADDR_W-1:0] rd_ptr [3]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [ADDR_W-1:0] regs [16];
    // Write-back wins over a software load of the same pointer
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            foreach (regs[i]) begin
                regs[i] <= RST_ADDR;
            end
        end else begin
            if (load_en) begin
                regs[load_sel] <= load_val;
            end
            for (int u = 0; u < 3; u++) begin
                if (wb_en[u]) begin
                    regs[wb_sel[u]] <= wb_data[u];
                end
            end
        end
    end
    always_comb begin
        for (int u = 0; u < 3; u++) begin
            rd_ptr[u] = regs[rd_sel[u]];
        end
    end
endmodule

// file: test/tb_top.sv
// Self-checking bench: APB register file and three address units against a model
module tb_top
    import agu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, e, m) begin total_checks++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t %s", $time, m); end end
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    logic u_val [3] = '{3{1'b0}};
    logic [SEL_W-1:0] u_sel [3] = '{3{4'h0}};
    addr_mode_e u_mode [3] = '{3{AM_DIRECT}};
    logic [15:0] u_off [3] = '{3{16'h0000}};
    logic u_byte [3] = '{3{1'b0}};
    wire o_val [3];
    wire [15:0] o_addr [3];
    wire o_we [3];
    wire [3:0] o_ws [3];
    wire [15:0] o_wd [3];
    wire [15:0] p_ptr [3];
    logic ld_en = 1'b0;
    logic [3:0] ld_sel = 4'h0;
    logic [15:0] ld_val = 16'h0000;
    logic [15:0] mc, br, xs, xe, ys, ye, st_ea;
    logic st_rev;
    logic e_val [3];
    logic e_we [3];
    logic [15:0] e_ea [3];
    logic [15:0] e_wd [3];
    logic [3:0] e_ws [3];
    logic [3:0] sel_tab [4] = '{4'h2, 4'h3, 4'h5, 4'hF};
    logic [11:0] ofs_tab [8] = '{OFS_MODULO_CTRL, OFS_BREV_CTRL, OFS_X_START, OFS_X_END,
        OFS_Y_START, OFS_Y_END, OFS_STATUS, 12'h01C};
    int seed = 83521;
    int failures = 0;
    int total_checks = 0;

    always #2 ref_clk = ~ref_clk;

    bit_reversed_modulo_agu uut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(1'b1),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .xw_valid(u_val[0]), .xw_ptr_sel(u_sel[0]), .xw_ptr(p_ptr[0]), .xw_mode(u_mode[0]),
        .xw_offset(u_off[0]), .xw_byte(u_byte[0]), .xw_addr_valid(o_val[0]),
        .xw_addr(o_addr[0]), .xw_wb_en(o_we[0]), .xw_wb_sel(o_ws[0]), .xw_wb_data(o_wd[0]),
        .xr_valid(u_val[1]), .xr_ptr_sel(u_sel[1]), .xr_ptr(p_ptr[1]), .xr_mode(u_mode[1]),
        .xr_offset(u_off[1]), .xr_byte(u_byte[1]), .xr_addr_valid(o_val[1]),
        .xr_addr(o_addr[1]), .xr_wb_en(o_we[1]), .xr_wb_sel(o_ws[1]), .xr_wb_data(o_wd[1]),
        .y_valid(u_val[2]), .y_ptr_sel(u_sel[2]), .y_ptr(p_ptr[2]), .y_mode(u_mode[2]),
        .y_offset(u_off[2]), .y_byte(u_byte[2]), .y_addr_valid(o_val[2]),
        .y_addr(o_addr[2]), .y_wb_en(o_we[2]), .y_wb_sel(o_ws[2]), .y_wb_data(o_wd[2]));

    pointer_file_model partner (.ref_clk(ref_clk), .rst_b(rst_b), .load_en(ld_en),
        .load_sel(ld_sel), .load_val(ld_val), .wb_en(o_we), .wb_sel(o_ws), .wb_data(o_wd),
        .rd_sel(u_sel), .rd_ptr(p_ptr));

    function automatic logic [14:0] rev15(input logic [14:0] x);
        for (int k = 0; k < 15; k++) begin
            rev15[k] = x[14-k];
        end
    endfunction

    // Carries run from the top bit down
    function automatic logic [14:0] rev_add(input logic [14:0] a, input logic [14:0] b);
        return rev15(rev15(a) + rev15(b));
    endfunction

    function automatic logic [31:0] reg_val(input logic [11:0] a);
        case (a)
            OFS_MODULO_CTRL: return {16'h0000, mc};
            OFS_BREV_CTRL: return {16'h0000, br};
            OFS_X_START: return {16'h0000, xs};
            OFS_X_END: return {16'h0000, xe};
            OFS_Y_START: return {16'h0000, ys};
            OFS_Y_END: return {16'h0000, ye};
            OFS_STATUS: return {15'h0000, st_rev, st_ea};
            default: return 32'h0000_0000;
        endcase
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        `CHK(n < 20, 1'b1, "no bus answer")
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] v);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, {16'($random(seed)), v}, q, e);
        case (a)
            OFS_MODULO_CTRL: mc = v;
            OFS_BREV_CTRL: br = v;
            OFS_X_START: xs = v;
            OFS_X_END: xe = v;
            OFS_Y_START: ys = v;
            OFS_Y_END: ye = v;
            default: ;
        endcase
    endtask

    task automatic check_regs();
        logic [31:0] q;
        logic e;
        foreach (ofs_tab[k]) begin
            apb(1'b0, ofs_tab[k], 32'h0000_0000, q, e);
            `CHK(q, reg_val(ofs_tab[k]), "register read")
            `CHK(e, ofs_tab[k] == 12'h01C, "bus error flag")
        end
        $display("register check done");
    endtask

    task automatic calc(input int u);
        logic [15:0] p, m, lo, hi, nw, st;
        logic up, mod_on, dis, rv;
        addr_mode_e md;
        p = p_ptr[u];
        md = u_mode[u];
        st = u_byte[u] ? BYTE_STEP : WORD_STEP;
        dis = br[15] && mc[11:8] != STACK_SEL;
        rv = u == 0 && dis && u_sel[u] == mc[11:8] && !u_byte[u]
            && (md == AM_PRE_INC || md == AM_POST_INC);
        lo = u == 2 ? ys : xs;
        hi = u == 2 ? ye : xe;
        mod_on = (u == 2 ? mc[14] && u_sel[u] == mc[7:4] : mc[15] && u_sel[u] == mc[3:0])
            && !(dis && u != 1);
        up = md == AM_PRE_INC || md == AM_POST_INC || (md == AM_OFFSET && !u_off[u][15]);
        case (md)
            AM_PRE_INC, AM_POST_INC: m = p + st;
            AM_PRE_DEC, AM_POST_DEC: m = p - st;
            AM_OFFSET: m = p + u_off[u];
            default: m = p;
        endcase
        if (mod_on && md != AM_DIRECT && up && m > hi) m = m - (hi - lo + 16'h0001);
        if (mod_on && md != AM_DIRECT && !up && m < lo) m = m + (hi - lo + 16'h0001);
        e_ea[u] = (md inside {AM_PRE_INC, AM_PRE_DEC, AM_OFFSET}) ? m : p;
        e_we[u] = md != AM_DIRECT && md != AM_OFFSET;
        e_wd[u] = m;
        if (rv) begin
            nw = {rev_add(p[15:1], br[14:0]), 1'b0};
            e_wd[u] = nw;
            e_ea[u] = md == AM_PRE_INC ? nw : {p[15:1], 1'b0};
            e_we[u] = 1'b1;
        end
        e_ws[u] = u_sel[u];
        e_val[u] = u_val[u];
        if (u == 0 && u_val[u]) begin
            st_ea = e_ea[u];
            st_rev = rv;
        end
    endtask

    task automatic run(input int n, input string nm);
        int r;
        for (int i = 0; i <= n; i++) begin
            @(posedge ref_clk);
            for (int u = 0; u < 3; u++) begin
                r = $random(seed);
                u_val[u] <= i < n && r[0];
                u_sel[u] <= sel_tab[r[2:1]];
                u_mode[u] <= addr_mode_e'(3'(r[15:8] % 6));
                u_off[u] <= {{10{r[21]}}, r[21:16]};
                u_byte[u] <= r[22];
            end
            r = $random(seed);
            ld_en <= r[0];
            ld_sel <= sel_tab[r[2:1]];
            ld_val <= 16'h0FF0 + 16'(r[14:8]);
            #1;
            for (int u = 0; u < 3 && i > 0; u++) begin
                `CHK(o_val[u], e_val[u], "address valid")
                if (e_val[u]) begin
                    `CHK(o_addr[u], e_ea[u], "effective address")
                    `CHK(o_we[u], e_we[u], "write-back enable")
                end
                if (e_val[u] && e_we[u]) begin
                    `CHK({o_ws[u], o_wd[u]}, {e_ws[u], e_wd[u]}, "write-back value")
                end
            end
            for (int u = 0; u < 3; u++) begin
                calc(u);
            end
        end
        $display("phase %s done", nm);
    endtask

    initial begin
        mc = RST_MODULO_CTRL;
        br = RST_BREV_CTRL;
        {xs, xe, ys, ye, st_ea} = '0;
        st_rev = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        check_regs();
        wr(OFS_X_START, 16'h1000);
        wr(OFS_X_END, 16'h101F);
        wr(OFS_Y_START, 16'h1000);
        wr(OFS_Y_END, 16'h103F);
        wr(OFS_MODULO_CTRL, 16'hCF32);
        wr(OFS_STATUS, 16'hFFFF);
        wr(12'h01C, 16'hFFFF);
        check_regs();
        run(300, "modulo");
        wr(OFS_BREV_CTRL, 16'h8008); // pivot of 8 words suits a 32-byte aligned buffer
        wr(OFS_MODULO_CTRL, 16'hC532);
        repeat (2) @(posedge ref_clk); // no unit request right after the control write
        run(300, "reversed");
        check_regs();
        wr(OFS_MODULO_CTRL, 16'hCF32);
        run(200, "stack select");
        check_regs();
        close_out();
    end

    initial begin
        #40000;
        failures++;
        $display("watchdog expired");
        close_out();
    end
endmodule
